// ### rtl/accel_defines.svh
/*
 * Constants shared by both ends of the sample-buffer link: register
 * offsets, field positions, mode codes and timing counts.
 * Assumes a 20 MHz system clock on both ends.
 */
`ifndef ACCEL_DEFINES_SVH
`define ACCEL_DEFINES_SVH

// ==========================================================
// device register offsets (6-bit serial address)
`define REG_EVENTS 6'h30
`define REG_DATA_FIRST 6'h32
`define REG_X_HI 6'h33
`define REG_Y_LO 6'h34
`define REG_Y_HI 6'h35
`define REG_Z_LO 6'h36
`define REG_DATA_LAST 6'h37
`define REG_BUF_CTRL 6'h38
`define REG_BUF_STATUS 6'h39
`define REG_ORIENT_CFG 6'h3B
`define REG_ORIENT_STAT 6'h3C

// ==========================================================
// field positions and codes
`define CMD_READ_BIT 7
`define CMD_MULTI_BIT 6
`define CTRL_MODE_HI 7
`define CTRL_MODE_LO 6
`define CTRL_TRIG_SEL_BIT 5
`define CTRL_LEVEL_HI 4
`define ORIENT_3D_BIT 3
`define MODE_BYPASS 2'h0
`define MODE_FIFO 2'h1
`define MODE_STREAM 2'h2
`define MODE_TRIGGER 2'h3
`define BUF_DEPTH 6'h20
`define CTRL_RESET 8'h00
`define ORIENT_CFG_RESET 8'h00

// ==========================================================
// host register offsets (APB byte addresses)
`define HREG_CMD 8'h00
`define HREG_WDATA 8'h04
`define HREG_RX_HI 8'h08
`define HREG_RX_LO 8'h0C
`define HREG_STATUS 8'h10
`define HCMD_LEN_HI 10
`define HCMD_LEN_LO 8

// ==========================================================
// timing
`define CLK_NS 50
`define HALF_SCLK_NS 200
`define HALF_SCLK_CYC (`HALF_SCLK_NS / `CLK_NS)
`define QUIET_NS 5000
`define QUIET_CYC ((`QUIET_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ### rtl/accel_pkg.sv
/*
 * Types shared by both ends of the sample-buffer link.
 * Assumes nothing beyond the constants header.
 */
package accel_pkg;

  // one buffer entry: a full three-axis sample
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } sample_s;

  typedef enum logic [1:0] {
    host_idle,
    host_lead,
    host_low,
    host_high
  } host_state_e;

endpackage

// ### rtl/accel_link_if.sv
/*
 * Four-wire serial link plus the two interrupt lines between the host
 * controller and the sensor's buffer block.
 * Assumes the data-out line idles high (pull-up) while not driven.
 */
`timescale 1ns/1ns

interface accel_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic miso_line;
  logic irq_out_first;
  logic irq_out_second;

  assign miso_line = miso_oe_n ? 1'b1 : miso;

  modport dev (
    input cs_n, sclk, mosi,
    output miso, miso_oe_n, irq_out_first, irq_out_second
  );
  modport host (
    output cs_n, sclk, mosi,
    input miso_line, irq_out_first, irq_out_second
  );
endinterface

// ### rtl/accel_sample_fifo_ctrl.sv
/*
 * Device end: 32-entry three-axis sample buffer with bypass, fifo,
 * stream and trigger modes, overrun/watermark/orientation flags, and a
 * serial slave (mode 3, command byte then data) reaching its registers.
 * Assumes the link pins are asynchronous to clk and that sample,
 * orientation and interrupt inputs come from logic on clk.
 */
`timescale 1ns/1ns
`include "accel_defines.svh"

// What this block does
// RQ1: bypass: overrun when unread sample replaced
// RQ2: buffered modes: overrun when buffer fills
// RQ3: reading buffer clears overrun automatically
// RQ4: orientation flag on valid-to-different-valid change
// RQ5: no flag on invalid or same orientation; invalid keeps last valid code
// RQ6: dead-zone orientation counts as invalid
// RQ7: config bit picks 2-D or 3-D set
// RQ8: 32 entries, four modes via mode field
// RQ9: bypass stores nothing, buffer stays empty
// RQ10: fifo mode stops storing when full
// RQ11: watermark when count reaches level field
// RQ12: watermark holds while count not below level
// RQ13: stream keeps newest 32, drops oldest
// RQ14: trigger keeps newest n, then fifo mode
// RQ15: host waits 5 us after trigger
// RQ16: trigger re-armed only via bypass then trigger
// RQ17: entering bypass empties the buffer
// RQ18: each read pops oldest entry into data regs
// RQ19: single-byte read pops whole entry
// RQ20: host leaves 5 us after data read
// RQ21: read ends at 0x37-to-0x38 step or chip-select release
// RQ22: host releases chip select between buffer reads
// RQ23: watermark clears when count drops below level
// RQ24: one entry per sample, count steps by one
module accel_sample_fifo_ctrl
  import accel_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  accel_link_if.dev link,
  // sensor core side
  input wire logic sample_valid,
  input wire sample_s sample,
  input wire logic orient_2d_valid,
  input wire logic [1:0] orient_2d_code,
  input wire logic orient_3d_valid,
  input wire logic [2:0] orient_3d_code,
  input wire logic irq_first_in,
  input wire logic irq_second_in,
  // status
  output logic overrun,
  output logic watermark,
  output logic orient_change,
  output logic [5:0] entries
);

  // ==========================================================
  // link synchronisers and edges
  logic [2:0] cs_q;
  logic [2:0] sclk_q;
  logic [1:0] mosi_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_q <= 3'h7;
      sclk_q <= 3'h7;
      mosi_q <= 2'h0;
    end else begin
      cs_q <= {cs_q[1:0], link.cs_n};
      sclk_q <= {sclk_q[1:0], link.sclk};
      mosi_q <= {mosi_q[0], link.mosi};
    end
  end

  wire active = ~cs_q[1];
  wire cs_rise = cs_q[1] & ~cs_q[2];
  wire sclk_rise = sclk_q[1] & ~sclk_q[2];
  wire sclk_fall = ~sclk_q[1] & sclk_q[2];

  // ==========================================================
  // serial slave
  logic [2:0] bit_cnt;
  logic cmd_phase;
  logic is_read;
  logic multi;
  logic [5:0] addr;
  logic [6:0] rx_sh;
  logic [6:0] tx_sh;
  logic miso_q;
  logic oe_n_q;
  logic read_pending;
  logic [7:0] ctrl;
  logic [7:0] orient_cfg;

  wire [7:0] rx_byte = {rx_sh, mosi_q[1]};
  wire byte_done = active & sclk_rise & (bit_cnt == 3'h7);
  wire load = active & sclk_fall & ~cmd_phase & is_read & (bit_cnt == 3'h0);
  wire data_addr = (addr >= `REG_DATA_FIRST) && (addr <= `REG_DATA_LAST);
  wire data_write = byte_done & ~cmd_phase & ~is_read;
  wire wr_ctrl = data_write & (addr == `REG_BUF_CTRL);
  wire wr_orient = data_write & (addr == `REG_ORIENT_CFG);
  // a data read ends when the burst leaves the data range or the frame ends
  wire read_done = read_pending & (cs_rise | (load & ~data_addr)); // see RQ21

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= 3'h0;
      cmd_phase <= 1'b1;
      is_read <= 1'b0;
      multi <= 1'b0;
      addr <= 6'h00;
      rx_sh <= 7'h00;
    end else if (!active) begin
      bit_cnt <= 3'h0;
      cmd_phase <= 1'b1;
    end else if (sclk_rise) begin
      rx_sh <= rx_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done && cmd_phase) begin
        cmd_phase <= 1'b0;
        is_read <= rx_byte[`CMD_READ_BIT];
        multi <= rx_byte[`CMD_MULTI_BIT];
        addr <= rx_byte[5:0];
      end else if (byte_done && multi) begin
        addr <= addr + 6'h01;
      end
    end
  end

  // read data leaves on falling edges, one byte per register address
  wire sample_s data_q;
  logic [5:0] count;
  logic triggered;
  logic last_ok;
  logic [2:0] last_code;
  wire [7:0] events = {5'h00, orient_change, watermark, overrun};
  wire [7:0] rd_byte =
    (addr == `REG_DATA_FIRST) ? data_q.x[7:0] :
    (addr == `REG_X_HI) ? data_q.x[15:8] :
    (addr == `REG_Y_LO) ? data_q.y[7:0] :
    (addr == `REG_Y_HI) ? data_q.y[15:8] :
    (addr == `REG_Z_LO) ? data_q.z[7:0] :
    (addr == `REG_DATA_LAST) ? data_q.z[15:8] :
    (addr == `REG_EVENTS) ? events :
    (addr == `REG_BUF_CTRL) ? ctrl :
    (addr == `REG_BUF_STATUS) ? {triggered, 1'b0, count} :
    (addr == `REG_ORIENT_CFG) ? orient_cfg :
    (addr == `REG_ORIENT_STAT) ? {orient_change, 3'h0, last_ok, last_code} : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      miso_q <= 1'b1;
      oe_n_q <= 1'b1;
      tx_sh <= 7'h00;
      read_pending <= 1'b0;
    end else begin
      if (!active) begin
        oe_n_q <= 1'b1;
      end else if (load) begin
        miso_q <= rd_byte[7];
        tx_sh <= rd_byte[6:0];
        oe_n_q <= 1'b0;
      end else if (sclk_fall && !cmd_phase && is_read) begin
        miso_q <= tx_sh[6];
        tx_sh <= {tx_sh[5:0], 1'b0};
      end
      if (read_done) begin
        read_pending <= 1'b0;
      end else if (load && data_addr) begin
        read_pending <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `CTRL_RESET;
      orient_cfg <= `ORIENT_CFG_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= rx_byte; // see RQ8
      end
      if (wr_orient) begin
        orient_cfg <= rx_byte;
      end
    end
  end

  // ==========================================================
  // sample buffer
  sample_s mem [0:31];
  sample_s data_r;
  logic [4:0] wr_ptr;
  logic [4:0] rd_ptr;
  logic irq_prev;
  logic unread;

  wire [1:0] mode = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire [4:0] level = ctrl[`CTRL_LEVEL_HI:0];
  wire bypass = (mode == `MODE_BYPASS);
  wire streaming = (mode == `MODE_STREAM) | ((mode == `MODE_TRIGGER) & ~triggered);
  wire full = (count == `BUF_DEPTH);
  wire trig_pin = ctrl[`CTRL_TRIG_SEL_BIT] ? irq_second_in : irq_first_in;
  // later events are ignored until bypass clears triggered
  wire trig_hit = (mode == `MODE_TRIGGER) & ~triggered & trig_pin & ~irq_prev; // see RQ16
  wire do_pop = read_done & ~bypass & (count != 6'h00); // see RQ18
  wire do_store = ~bypass & sample_valid & ~trig_hit & (~full | do_pop | streaming); // see RQ10
  wire do_drop = do_store & full & ~do_pop; // see RQ13
  wire [5:0] count_next = 6'(count + {5'h00, do_store} - {5'h00, do_pop} - {5'h00, do_drop}); // see RQ24
  wire trim = trig_hit & (count > {1'b0, level});

  assign data_q = data_r;

  always_ff @(posedge clk) begin
    if (do_store) begin
      mem[wr_ptr] <= sample;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= 5'h00;
      rd_ptr <= 5'h00;
      count <= 6'h00;
      triggered <= 1'b0;
      irq_prev <= 1'b0;
    end else begin
      irq_prev <= trig_pin;
      if (bypass) begin
        wr_ptr <= 5'h00; // see RQ9
        rd_ptr <= 5'h00;
        count <= 6'h00; // see RQ17
        triggered <= 1'b0;
      end else if (trig_hit) begin
        triggered <= 1'b1; // see RQ14
        if (trim) begin
          rd_ptr <= wr_ptr - level;
          count <= {1'b0, level};
        end
      end else begin
        if (do_store) begin
          wr_ptr <= wr_ptr + 5'h01;
        end
        if (do_pop || do_drop) begin
          rd_ptr <= rd_ptr + 5'h01;
        end
        count <= count_next;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_r <= '0;
      unread <= 1'b0;
    end else if (bypass && sample_valid) begin
      data_r <= sample;
      unread <= 1'b1;
    end else begin
      if (do_pop) begin
        data_r <= mem[rd_ptr]; // see RQ19
      end
      if (read_done) begin
        unread <= 1'b0;
      end
    end
  end

  // ==========================================================
  // flags: a new event in the clearing cycle wins
  wire ovr_set = (bypass & sample_valid & unread) // see RQ1
               | (do_store & (count_next == `BUF_DEPTH)); // see RQ2
  assign watermark = ~bypass & (count >= {1'b0, level}); // see RQ11 see RQ12 see RQ23
  assign entries = count;

  wire [2:0] o_code = orient_cfg[`ORIENT_3D_BIT] ? orient_3d_code : {1'b0, orient_2d_code}; // see RQ7
  wire o_valid = orient_cfg[`ORIENT_3D_BIT] ? orient_3d_valid : orient_2d_valid; // see RQ6
  wire o_set = o_valid & last_ok & (o_code != last_code); // see RQ4 see RQ5
  wire o_clr = load & (addr == `REG_ORIENT_STAT);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overrun <= 1'b0;
      orient_change <= 1'b0;
      last_ok <= 1'b0;
      last_code <= 3'h0;
    end else begin
      overrun <= ovr_set | (overrun & ~read_done); // see RQ3
      orient_change <= o_set | (orient_change & ~o_clr);
      if (wr_orient) begin
        last_ok <= 1'b0;
      end else if (o_valid) begin
        last_ok <= 1'b1;
        last_code <= o_code;
      end
    end
  end

  // ==========================================================
  // link outputs
  logic irq1_q;
  logic irq2_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq1_q <= 1'b0;
      irq2_q <= 1'b0;
    end else begin
      irq1_q <= irq_first_in;
      irq2_q <= irq_second_in;
    end
  end

  assign link.miso = miso_q;
  assign link.miso_oe_n = oe_n_q;
  assign link.irq_out_first = irq1_q;
  assign link.irq_out_second = irq2_q;

endmodule

// ### rtl/accel_host_ctrl.sv
/*
 * Host end: APB slave taking a command and holding write data, received data and
 * status, and a mode-3 serial master that runs one frame per command.
 * Assumes APB on clk; the link and interrupt lines are asynchronous.
 */
`timescale 1ns/1ns
`include "accel_defines.svh"

module accel_host_ctrl
  import accel_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  accel_link_if.host link
);

  // ==========================================================
  // input synchronisers
  logic [1:0] miso_q;
  logic [2:0] irq_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      miso_q <= 2'h3;
      irq_q <= 3'h0;
    end else begin
      miso_q <= {miso_q[0], link.miso_line};
      irq_q <= {irq_q[1:0], link.irq_out_first | link.irq_out_second};
    end
  end

  // ==========================================================
  // apb: answer two cycles after setup, data from flops
  host_state_e state;
  logic [6:0] quiet;
  logic [63:0] rx_sh;
  logic [31:0] wdata;
  logic rdy_q;
  logic [31:0] rd_q;
  logic err_q;

  wire busy = (state != host_idle) | (quiet != 7'h00);
  wire access = psel & penable & ~rdy_q;
  wire commit = psel & penable & rdy_q & pwrite;
  wire mapped = (paddr == `HREG_CMD) | (paddr == `HREG_WDATA) | (paddr == `HREG_RX_HI)
              | (paddr == `HREG_RX_LO) | (paddr == `HREG_STATUS);
  wire start = commit & (paddr == `HREG_CMD) & ~busy;
  wire [31:0] rd_mux =
    (paddr == `HREG_WDATA) ? wdata :
    (paddr == `HREG_RX_HI) ? rx_sh[63:32] :
    (paddr == `HREG_RX_LO) ? rx_sh[31:0] :
    (paddr == `HREG_STATUS) ? {31'h0, busy} : 32'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdy_q <= 1'b0;
      rd_q <= 32'h0;
      err_q <= 1'b0;
      wdata <= 32'h0;
    end else begin
      rdy_q <= access;
      if (access) begin
        rd_q <= rd_mux;
        err_q <= ~mapped;
      end
      if (commit && paddr == `HREG_WDATA) begin
        wdata <= pwdata;
      end
    end
  end

  assign pready = rdy_q;
  assign prdata = rd_q;
  assign pslverr = rdy_q & err_q;

  // ==========================================================
  // serial master: sclk idles high, mosi changes on fall
  // miso is taken at the end of the high half: the slave answers about three
  // clocks after each fall and the synchroniser adds two more
  logic [2:0] half;
  logic [6:0] bits_left;
  logic [39:0] tx_sh;
  logic cs_q;
  logic sclk_q;
  logic mosi_q;

  wire half_done = (half == 3'(`HALF_SCLK_CYC - 1));
  wire irq_rise = irq_q[1] & ~irq_q[2];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= host_idle;
      half <= 3'h0;
      bits_left <= 7'h00;
      tx_sh <= 40'h0;
      rx_sh <= 64'h0;
      cs_q <= 1'b1;
      sclk_q <= 1'b1;
      mosi_q <= 1'b1;
      quiet <= 7'h00;
    end else begin
      half <= half_done ? 3'h0 : half + 3'h1;
      if (irq_rise) begin
        quiet <= 7'(`QUIET_CYC); // see RQ15
      end else if (quiet != 7'h00 && state == host_idle) begin
        quiet <= quiet - 7'h01;
      end
      unique case (state)
        host_idle: begin
          half <= 3'h0;
          if (start) begin
            state <= host_lead;
            cs_q <= 1'b0;
            tx_sh <= {pwdata[7:0], wdata};
            bits_left <= 7'({pwdata[`HCMD_LEN_HI:`HCMD_LEN_LO], 3'h0}) + 7'h10;
          end
        end
        host_lead, host_high: begin
          if (half_done) begin
            if (state == host_high) begin
              rx_sh <= {rx_sh[62:0], miso_q[1]};
            end
            if (bits_left == 7'h00) begin
              state <= host_idle;
              cs_q <= 1'b1; // see RQ22
              quiet <= 7'(`QUIET_CYC); // see RQ20
            end else begin
              state <= host_low;
              sclk_q <= 1'b0;
              mosi_q <= tx_sh[39];
              tx_sh <= {tx_sh[38:0], 1'b0};
            end
          end
        end
        host_low: begin
          if (half_done) begin
            state <= host_high;
            sclk_q <= 1'b1;
            bits_left <= bits_left - 7'h01;
          end
        end
      endcase
    end
  end

  assign link.cs_n = cs_q;
  assign link.sclk = sclk_q;
  assign link.mosi = mosi_q;

endmodule

// ### test/accel_link_assertions.sv
/*
 * Checker for the link between host controller and sample buffer:
 * serial clock shape, chip-select spacing and buffer count.
 * Assumes the bench hands in the link signals and the device status.
 */
`timescale 1ns/1ns

module accel_link_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic miso_oe_n,
  // device status
  input wire logic overrun,
  input wire logic [5:0] entries
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ====
  // quiet time since chip select rose; saturates so idle periods stay legal
  logic [6:0] quiet_cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet_cnt <= 7'h64;
    end else if (!cs_n) begin
      quiet_cnt <= 7'h00;
    end else if (quiet_cnt != 7'h64) begin
      quiet_cnt <= quiet_cnt + 7'h01;
    end
  end

  // ====
  // serial framing
  sequence low_half;
    (!sclk)[*4] ##1 sclk;
  endsequence
  sequence high_half;
    sclk[*4];
  endsequence

  idle_clock_high_a: assert property (cs_n |-> sclk) else $error("clock not idle high");
  frame_lead_in_a: assert property ($fell(cs_n) |-> high_half) else $error("short lead-in");
  clock_low_half_a: assert property ($fell(sclk) |-> low_half) else $error("bad low half");
  clock_high_half_a: assert property ($rose(sclk) && !cs_n |-> high_half) else $error("bad high half");
  frame_spacing_a: assert property ($fell(cs_n) |-> quiet_cnt >= 7'h64) else $error("frames too close");
  data_release_a: assert property ($rose(cs_n) |-> ##[0:4] miso_oe_n) else $error("data line held");

  // ====
  // buffer count
  depth_limit_a: assert property (entries <= 6'h20) else $error("count above depth");
  count_step_a: assert property (entries > $past(entries) |-> entries == $past(entries) + 6'h01)
    else $error("count jumped");
  full_overrun_a: assert property ($rose(entries == 6'h20) |-> ##[0:2] overrun) else $error("no overrun");
endmodule

// ### test/testbench.sv
/*
 * Bench: host controller and sample buffer joined by the link, driven
 * over APB, with a queue model of the buffer.
 * Assumes the rtl files and the constants header are compiled first.
 */
`timescale 1ns/1ns
`include "accel_defines.svh"

module testbench
  import accel_pkg::*;
;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r_data;
  logic sample_valid = 0, orient_2d_valid = 0, orient_3d_valid = 0, irq_first_in = 0, irq_second_in = 0;
  logic [1:0] orient_2d_code = 2'h0, md = 2'h0;
  logic [2:0] orient_3d_code = 3'h0;
  logic overrun, watermark, orient_change, r_err, last_ok = 1, sel = 0, trig = 0;
  logic [5:0] entries;
  logic [4:0] lvl = 5'h00;
  logic [63:0] rx;
  sample_s sample = '0, last = '0;
  sample_s q[$];
  int seed = 86, mismatches = 0, compares = 0;

  always #25 clk = ~clk;

  accel_link_if link();
  accel_host_ctrl accel_host_ctrl_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  accel_sample_fifo_ctrl accel_sample_fifo_ctrl_i (.clk(clk), .rst(rst), .link(link),
    .sample_valid(sample_valid), .sample(sample), .orient_2d_valid(orient_2d_valid),
    .orient_2d_code(orient_2d_code), .orient_3d_valid(orient_3d_valid), .orient_3d_code(orient_3d_code),
    .irq_first_in(irq_first_in), .irq_second_in(irq_second_in), .overrun(overrun), .watermark(watermark),
    .orient_change(orient_change), .entries(entries));
  accel_link_assertions accel_link_assertions_i (.clk(clk), .rst(rst), .cs_n(link.cs_n), .sclk(link.sclk),
    .miso_oe_n(link.miso_oe_n), .overrun(overrun), .entries(entries));

  // ====
  // reporting
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic done_t(input string s);
    $display("test %s done", s);
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [47:0] swapb(sample_s s);
    return {s.x[7:0], s.x[15:8], s.y[7:0], s.y[15:8], s.z[7:0], s.z[15:8]};
  endfunction

  // ====
  // bus and link
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // busy covers a running frame and the quiet time after a frame or an interrupt edge
  task automatic wait_idle();
    logic [31:0] r;
    logic e;
    do begin
      apb(1'h0, `HREG_STATUS, 32'h0, r, e);
    end while (r[0] !== 1'h0);
  endtask

  // one frame per command; a command written while busy would be dropped
  task automatic frame(input logic [7:0] cmd, input int n, input logic [31:0] wd);
    logic [31:0] r;
    logic e;
    wait_idle();
    apb(1'h1, `HREG_WDATA, wd, r, e);
    apb(1'h1, `HREG_CMD, {21'h0, 3'(n - 1), cmd}, r, e);
    wait_idle();
    apb(1'h0, `HREG_RX_HI, 32'h0, r, e);
    rx[63:32] = r;
    apb(1'h0, `HREG_RX_LO, 32'h0, r, e);
    rx[31:0] = r;
  endtask

  task automatic dev_wr(input logic [5:0] a, input logic [7:0] v);
    frame({2'h0, a}, 1, {v, 24'h0});
  endtask

  task automatic chk_state();
    chk(entries, q.size());
    chk(watermark, md != `MODE_BYPASS && q.size() >= lvl);
  endtask

  task automatic set_mode(input logic [7:0] v);
    dev_wr(`REG_BUF_CTRL, v);
    md = v[7:6];
    sel = v[5];
    lvl = v[4:0];
    if (md == `MODE_BYPASS) begin
      q.delete();
      trig = 0;
      last_ok = 0;
    end
  endtask

  task automatic push(input int n);
    logic [63:0] r;
    repeat (n) begin
      r = {$random(seed), $random(seed)};
      @(posedge clk);
      sample_valid <= 1;
      sample <= r[47:0];
      @(posedge clk);
      sample_valid <= 0;
      if (md != `MODE_BYPASS) q.push_back(r[47:0]);
      if (q.size() > 32 && (md == `MODE_STREAM || (md == `MODE_TRIGGER && !trig))) void'(q.pop_front());
      if (q.size() > 32) void'(q.pop_back());
      repeat (2) @(posedge clk);
      chk_state();
    end
  endtask

  // data registers show the entry moved in by the previous read
  task automatic read_s(input logic multi);
    frame(multi ? {2'h3, `REG_DATA_FIRST} : {2'h2, `REG_DATA_FIRST}, multi ? 6 : 1, 32'h0);
    if (last_ok && multi) chk(rx[47:0], swapb(last));
    if (last_ok && !multi) chk(rx[7:0], last.x[7:0]);
    if (q.size() > 0) begin
      last = q.pop_front();
      last_ok = 1;
    end
    chk_state();
  endtask

  task automatic pulse(input logic pin);
    @(posedge clk);
    {irq_second_in, irq_first_in} <= pin ? 2'h2 : 2'h1;
    repeat (3) @(posedge clk);
    {irq_second_in, irq_first_in} <= 2'h0;
    if (md == `MODE_TRIGGER && !trig && sel == pin) begin
      trig = 1;
      while (q.size() > lvl) void'(q.pop_front());
    end
    repeat (5) @(posedge clk);
    chk_state();
  endtask

  task automatic orient(input logic v2, input logic [1:0] c2, input logic v3, input logic [2:0] c3);
    @(posedge clk);
    orient_2d_valid <= v2;
    orient_2d_code <= c2;
    orient_3d_valid <= v3;
    orient_3d_code <= c3;
    repeat (4) @(posedge clk);
  endtask

  // ====
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    apb(1'h0, 8'h20, 32'h0, r_data, r_err);
    chk(r_err, 1'h1);
    set_mode({`MODE_FIFO, 1'h0, 5'h04});
    push(33);
    chk(entries, 6'h20);
    chk(overrun, 1'h1);
    frame({2'h2, `REG_EVENTS}, 1, 32'h0);
    chk(rx[7:0], 8'h03);
    done_t("fifo fill");
    for (int i = 0; i < 29; i++) begin
      read_s(i != 5);
      if (i == 0) chk(overrun, 1'h0);
    end
    done_t("drain");
    set_mode(8'h00);
    chk(entries, 6'h00);
    set_mode({`MODE_STREAM, 1'h0, 5'h08});
    push(34);
    read_s(1'h1);
    read_s(1'h1);
    done_t("stream");
    set_mode(8'h00);
    set_mode({`MODE_TRIGGER, 1'h0, 5'h05});
    push(10);
    pulse(1'h0);
    push(2);
    pulse(1'h0);
    frame({2'h2, `REG_BUF_STATUS}, 1, 32'h0);
    chk(rx[7:0], {2'h2, 6'(q.size())});
    set_mode(8'h00);
    set_mode({`MODE_TRIGGER, 1'h1, 5'h02});
    push(4);
    pulse(1'h0);
    pulse(1'h1);
    done_t("trigger");
    set_mode(8'h00);
    push(2);
    chk(overrun, 1'h1);
    chk(entries, 6'h00);
    read_s(1'h1);
    chk(overrun, 1'h0);
    done_t("bypass");
    orient(1'h1, 2'h0, 1'h0, 3'h0);
    orient(1'h1, 2'h1, 1'h0, 3'h0);
    chk(orient_change, 1'h1);
    frame({2'h2, `REG_ORIENT_STAT}, 1, 32'h0);
    chk(rx[7:0], 8'h89);
    orient(1'h0, 2'h2, 1'h0, 3'h0);
    orient(1'h1, 2'h1, 1'h0, 3'h0);
    chk(orient_change, 1'h0);
    dev_wr(`REG_ORIENT_CFG, 8'h08);
    orient(1'h1, 2'h1, 1'h1, 3'h1);
    orient(1'h1, 2'h3, 1'h1, 3'h1);
    chk(orient_change, 1'h0);
    orient(1'h1, 2'h3, 1'h1, 3'h4);
    chk(orient_change, 1'h1);
    done_t("orientation");
    finish_test();
  end

  // about 50k cycles, twice the expected run
  initial begin
    #2500000;
    mismatches++;
    finish_test();
  end
endmodule
